// >>> hdl/sfp_pin_frontend.sv
`timescale 1ns/1ps
module sfp_pin_frontend (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  // Flash pins
  input sfp_pkg::sfp_pins_s pinIn,
  output sfp_pkg::sfp_drive_s pinDrive,
  // Configuration bits
  input wire logic quadEnable,
  input wire logic pinFunctionSelect,
  input wire logic statusProtectBit,
  // Transfer control from command logic
  input sfp_pkg::sfp_width_e laneMode,
  input wire logic outPhase,
  input wire logic [7:0] txByte,
  output logic txTake,
  output logic [7:0] rxByte,
  output logic rxValid,
  // Status
  output logic selected,
  output logic paused,
  output logic armed,
  output logic frameStart,
  output logic frameEnd,
  output logic hwResetPulse,
  output logic writeProtectActive,
  output logic statusWriteBlocked
);
  import sfp_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  sfp_pins_s pinSync; // Pins after two flip-flops
  logic syncWarm; // High until the synchroniser holds real pin levels
  logic sclkD_reg; // Previous synchronised serial clock
  logic sclkRise; // Serial clock rising edge seen
  logic sclkFall; // Serial clock falling edge seen
  logic csHigh; // Device deselected by pin
  logic holdLow; // Pause input asserted
  logic resetLow; // Reset input asserted
  logic wpLow; // Write-protect input asserted
  sfp_state_e state_reg; // Frame state
  sfp_state_e state_next;
  logic [RST_CNT_W-1:0] rstCnt_reg; // Reset low time counter
  logic resetFire; // Reset low long enough
  logic resetSeen_reg; // Reset already issued for this low time
  sfp_width_e effMode; // Width actually used
  logic [CNT_W-1:0] step; // Bits per serial clock
  logic [LANES-1:0] oeMask; // Lanes driven in this width
  logic [CNT_W-1:0] bitCnt_reg; // Bits moved in current byte
  logic [CNT_W-1:0] bitSum; // Count after this edge
  logic [7:0] rxShift_reg; // Incoming shift register
  logic [7:0] rxNext; // Shift register after this edge
  logic [7:0] txShift_reg; // Outgoing shift register
  logic [7:0] txCur; // Byte whose top bits go out now
  logic [LANES-1:0] laneBits; // Top bits of txCur placed on lanes

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  sfp_sync #(
    .W(PIN_W)
  ) uSync (
    .mclk(mclk),
    .srst(srst),
    .clkEn(clkEn),
    .d(pinIn),
    .q(pinSync)
  );

  // Warm-up flag: the synchroniser resets to all ones, so a select pin held
  // low since power-up would look high for two edges and arm the device
  sfp_sync #(
    .W(1)
  ) uWarm (
    .mclk(mclk),
    .srst(srst),
    .clkEn(clkEn),
    .d(1'b0),
    .q(syncWarm)
  );

  // ----------------------------------------
  // Pin decode
  // ----------------------------------------
  // Serial clock edge detector on the synchronised level
  // Reset matches the synchroniser's reset level, so no false rise follows reset
  always_ff @(posedge mclk) begin
    if (srst) begin
      sclkD_reg <= 1'b1;
    end else if (clkEn) begin
      sclkD_reg <= pinSync.sclk;
    end
  end

  assign sclkRise = pinSync.sclk & ~sclkD_reg;
  assign sclkFall = ~pinSync.sclk & sclkD_reg;
  assign csHigh = pinSync.selectN;
  // Lane two is the write-protect input only without quad
  assign wpLow = ~quadEnable & ~pinSync.lanes[LANE_TWO];
  // Lane three is pause or reset only without quad
  assign holdLow = ~quadEnable & (pinFunctionSelect == PIN_FN_PAUSE)
                   & ~pinSync.lanes[LANE_THREE];
  assign resetLow = ~quadEnable & (pinFunctionSelect == PIN_FN_RESET)
                    & ~pinSync.lanes[LANE_THREE];

  // ----------------------------------------
  // Hardware reset timing
  // ----------------------------------------
  // Count cycles of reset low, regardless of select, clock or data
  always_ff @(posedge mclk) begin
    if (srst) begin
      rstCnt_reg <= '0;
      resetSeen_reg <= 1'b0;
    end else if (clkEn) begin
      if (!resetLow) begin
        // Released: start over
        rstCnt_reg <= '0;
        resetSeen_reg <= 1'b0;
      end else if (resetFire) begin
        // Issue once per low time
        resetSeen_reg <= 1'b1;
      end else if (!resetSeen_reg) begin
        rstCnt_reg <= rstCnt_reg + 1'b1;
      end
    end
  end

  assign resetFire = resetLow & ~resetSeen_reg & (rstCnt_reg == RST_FIRE);

  // Abort pulse to the rest of the device
  always_ff @(posedge mclk) begin
    if (srst) begin
      hwResetPulse <= 1'b0;
    end else if (clkEn) begin
      hwResetPulse <= resetFire;
    end
  end

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  // Next state from select, pause and reset
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // Wait for select high so a later fall counts
      ST_WAIT_ARM: begin
        if (csHigh && !syncWarm) begin
          state_next = ST_IDLE;
        end
      end
      // Deselected, bus ignored
      ST_IDLE: begin
        if (!csHigh) begin
          state_next = ST_ACTIVE;
        end
      end
      // Selected and moving bits
      ST_ACTIVE: begin
        if (csHigh) begin
          state_next = ST_IDLE;
        end else if (holdLow) begin
          state_next = ST_PAUSED;
        end
      end
      // Paused mid transfer
      ST_PAUSED: begin
        if (csHigh) begin
          state_next = ST_IDLE;
        end else if (!holdLow) begin
          state_next = ST_ACTIVE;
        end
      end
      // Held in reset until the pin returns high
      ST_RESET: begin
        if (!resetLow) begin
          state_next = ST_WAIT_ARM;
        end
      end
      // Illegal code: rearm
      default: begin
        state_next = ST_WAIT_ARM;
      end
    endcase
    // Reset wins over everything
    if (resetFire) begin
      state_next = ST_RESET;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_reg <= ST_WAIT_ARM;
    end else if (clkEn) begin
      state_reg <= state_next;
    end
  end

  // Frame status flags and edge pulses
  always_ff @(posedge mclk) begin
    if (srst) begin
      selected <= 1'b0;
      paused <= 1'b0;
      armed <= 1'b0;
      frameStart <= 1'b0;
      frameEnd <= 1'b0;
    end else if (clkEn) begin
      selected <= (state_next == ST_ACTIVE) || (state_next == ST_PAUSED);
      paused <= state_next == ST_PAUSED;
      armed <= (state_next != ST_WAIT_ARM) && (state_next != ST_RESET);
      frameStart <= (state_reg == ST_IDLE) && (state_next == ST_ACTIVE);
      frameEnd <= ((state_reg == ST_ACTIVE) || (state_reg == ST_PAUSED))
                  && (state_next != ST_ACTIVE) && (state_next != ST_PAUSED);
    end
  end

  // ----------------------------------------
  // Lane width
  // ----------------------------------------
  // Quad needs quad enable; otherwise fall back to single
  always_comb begin
    effMode = laneMode;
    if ((laneMode == WIDTH_QUAD) && !quadEnable) begin
      effMode = WIDTH_SINGLE;
    end
    unique case (effMode)
      WIDTH_SINGLE: begin
        step = STEP_SINGLE;
        oeMask = OE_SINGLE;
      end
      WIDTH_DUAL: begin
        step = STEP_DUAL;
        oeMask = OE_DUAL;
      end
      WIDTH_QUAD: begin
        step = STEP_QUAD;
        oeMask = OE_QUAD;
      end
      // Unused code: treat as single
      default: begin
        step = STEP_SINGLE;
        oeMask = OE_SINGLE;
      end
    endcase
  end

  // ----------------------------------------
  // Input shifting
  // ----------------------------------------
  assign bitSum = bitCnt_reg + step;

  // New bits enter at the bottom, highest lane first
  always_comb begin
    unique case (step)
      STEP_QUAD: rxNext = {rxShift_reg[3:0], pinSync.lanes};
      STEP_DUAL: rxNext = {rxShift_reg[5:0], pinSync.lanes[LANE_ONE],
                           pinSync.lanes[LANE_ZERO]};
      default: rxNext = {rxShift_reg[6:0], pinSync.lanes[LANE_ZERO]};
    endcase
  end

  // Bit counter: moves only while active, frozen while paused
  always_ff @(posedge mclk) begin
    if (srst) begin
      bitCnt_reg <= '0;
    end else if (clkEn) begin
      if (state_reg != ST_ACTIVE && state_reg != ST_PAUSED) begin
        bitCnt_reg <= '0;
      end else if (state_reg == ST_ACTIVE && sclkRise && !csHigh) begin
        bitCnt_reg <= (bitSum >= BYTE_DONE) ? '0 : bitSum;
      end
    end
  end

  // Capture on rising edges while receiving
  always_ff @(posedge mclk) begin
    if (srst) begin
      rxShift_reg <= '0;
      rxByte <= '0;
      rxValid <= 1'b0;
    end else if (clkEn) begin
      rxValid <= 1'b0;
      if (state_reg == ST_ACTIVE && sclkRise && !csHigh && !outPhase) begin
        rxShift_reg <= rxNext;
        if (bitSum >= BYTE_DONE) begin
          rxByte <= rxNext;
          rxValid <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Output shifting
  // ----------------------------------------
  // Fresh byte at the start of each byte, else the shifted remainder
  assign txCur = (bitCnt_reg == '0) ? txByte : txShift_reg;

  // Place the top bits of the byte on the lanes of this width
  always_comb begin
    laneBits = '0;
    unique case (step)
      STEP_QUAD: laneBits = txCur[7:4];
      STEP_DUAL: laneBits[LANE_ONE:LANE_ZERO] = txCur[7:6];
      default: laneBits[LANE_ONE] = txCur[7];
    endcase
  end

  // Drive data on falling edges while sending
  always_ff @(posedge mclk) begin
    if (srst) begin
      txShift_reg <= '0;
      txTake <= 1'b0;
      pinDrive.laneOut <= '0;
    end else if (clkEn) begin
      txTake <= 1'b0;
      if (state_reg == ST_ACTIVE && sclkFall && !csHigh && outPhase) begin
        pinDrive.laneOut <= laneBits;
        txShift_reg <= txCur << step;
        txTake <= bitCnt_reg == '0;
      end
    end
  end

  // Enables: only while selected, not paused, and sending
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinDrive.laneOe <= OE_NONE;
    end else if (clkEn) begin
      if (state_next == ST_ACTIVE && outPhase) begin
        pinDrive.laneOe <= oeMask;
      end else begin
        pinDrive.laneOe <= OE_NONE;
      end
    end
  end

  // ----------------------------------------
  // Write protection
  // ----------------------------------------
  // Status writes are blocked while protect bit and pin are both set
  always_ff @(posedge mclk) begin
    if (srst) begin
      writeProtectActive <= 1'b0;
      statusWriteBlocked <= 1'b0;
    end else if (clkEn) begin
      writeProtectActive <= wpLow;
      statusWriteBlocked <= statusProtectBit & wpLow;
    end
  end

endmodule // sfp_pin_frontend

// >>> hdl/sfp_pkg.sv
package sfp_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 100; // Period of mclk
  localparam int RESET_MIN_NS = 1000; // Least low time of the reset input
  // Least time rounds up to whole cycles
  localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = $clog2(RESET_MIN_CYC + 1);
  localparam logic [RST_CNT_W-1:0] RST_FIRE = RST_CNT_W'(RESET_MIN_CYC - 1);

  // ----------------------------------------
  // Widths and lane positions
  // ----------------------------------------
  localparam int BYTE_BITS = 8; // Bits in a transferred byte
  localparam int LANES = 4; // Data lanes on the pins
  localparam int CNT_W = 4; // Bit counter width
  localparam int PIN_W = 6; // Sampled pin bundle width
  localparam int LANE_ZERO = 0;
  localparam int LANE_ONE = 1;
  localparam int LANE_TWO = 2;
  localparam int LANE_THREE = 3;
  localparam logic [CNT_W-1:0] BYTE_DONE = 4'h8; // Bit count of a full byte
  localparam logic [CNT_W-1:0] STEP_SINGLE = 4'h1; // Bits per clock, single
  localparam logic [CNT_W-1:0] STEP_DUAL = 4'h2; // Bits per clock, dual
  localparam logic [CNT_W-1:0] STEP_QUAD = 4'h4; // Bits per clock, quad
  localparam logic [LANES-1:0] OE_NONE = 4'h0; // No lane driven
  localparam logic [LANES-1:0] OE_SINGLE = 4'h2; // Only lane one driven
  localparam logic [LANES-1:0] OE_DUAL = 4'h3; // Lanes zero and one
  localparam logic [LANES-1:0] OE_QUAD = 4'hf; // All four lanes
  localparam logic PIN_FN_PAUSE = 1'b0; // Shared pin used as pause (reset value)
  localparam logic PIN_FN_RESET = 1'b1; // Shared pin used as hardware reset

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    WIDTH_SINGLE = 2'b00,
    WIDTH_DUAL = 2'b01,
    WIDTH_QUAD = 2'b10
  } sfp_width_e;

  typedef enum logic [2:0] {
    ST_WAIT_ARM = 3'b000,
    ST_IDLE = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_PAUSED = 3'b011,
    ST_RESET = 3'b100
  } sfp_state_e;

  // Raw pin levels as they arrive
  typedef struct packed {
    logic selectN;
    logic sclk;
    logic [LANES-1:0] lanes;
  } sfp_pins_s;

  // Lane drive towards the pins
  typedef struct packed {
    logic [LANES-1:0] laneOut;
    logic [LANES-1:0] laneOe;
  } sfp_drive_s;

endpackage

// >>> hdl/sfp_sync.sv
`timescale 1ns/1ps
module sfp_sync #(
  parameter int W = 1
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clkEn,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg; // First stage, read only by second stage

  // ----------------------------------------
  // Two flip-flop synchroniser
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      meta_reg <= '1;
      q <= '1;
    end else if (clkEn) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule // sfp_sync

// >>> testbench/sfp_host_model.sv
`timescale 1ns/1ps
module sfp_host_model (
  // Clock
  input wire logic mclk,
  // Pins
  input sfp_pkg::sfp_drive_s pinDrive,
  output sfp_pkg::sfp_pins_s pinIn
);
  import sfp_pkg::*;

  logic selN = 1'b0; // Select, low at power-up
  logic sclk = 1'b0; // Serial clock, still outside frames
  logic [3:0] hostLane = 4'hf; // Host drive on each lane
  logic [7:0] txSh; // Bits to send, top first
  logic [7:0] rxSh; // Bits collected from the device
  int bpc = 1; // Bits per serial clock

  // Device drive wins on enabled lanes
  assign pinIn = {selN, sclk, (pinDrive.laneOe & pinDrive.laneOut) | (~pinDrive.laneOe & hostLane)};

  // Wait edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #10;
  endtask

  // Serial clocks: present data, collect, rise, fall
  task automatic clocks(input int n);
    for (int i = 0; i < n; i++) begin
      for (int b = 0; b < bpc; b++) begin
        hostLane[b] = txSh[8 - bpc + b];
      end
      txSh = txSh << bpc;
      tick(5);
      // Collect just before the rise what the device put out at the last fall
      for (int b = bpc - 1; b >= 0; b--) begin
        rxSh = {rxSh[6:0], pinIn.lanes[bpc == 1 ? 1 : b]};
      end
      sclk = 1'b1;
      tick(5);
      sclk = 1'b0;
      tick(5);
    end
  endtask
endmodule // sfp_host_model

// >>> testbench/sfp_pin_frontend_monitor.sv
`timescale 1ns/1ps
module sfp_pin_frontend_monitor (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Pins
  input sfp_pkg::sfp_pins_s pinIn,
  input sfp_pkg::sfp_drive_s pinDrive,
  // Configuration
  input wire logic quadEnable,
  input wire logic pinFunctionSelect,
  input wire logic statusProtectBit,
  // Status
  input wire logic rxValid,
  input wire logic selected,
  input wire logic paused,
  input wire logic armed,
  input wire logic frameStart,
  input wire logic hwResetPulse,
  input wire logic writeProtectActive,
  input wire logic statusWriteBlocked
);
  import sfp_pkg::*;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  default clocking dc @(posedge mclk); endclocking
  default disable iff (srst);

  logic [4:0] lowCnt; // Edges the shared pin has stayed low
  // Raw low time of the shared pin, saturating
  always_ff @(posedge mclk) begin
    if (pinIn.lanes[LANE_THREE]) begin
      lowCnt <= 5'h0;
    end else if (lowCnt != 5'h1f) begin
      lowCnt <= lowCnt + 5'h1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_idle_released: assert property (!selected |-> pinDrive.laneOe == 4'h0)
    else $error("lane driven while deselected");
  chk_pause_released: assert property ($rose(paused) |-> pinDrive.laneOe == 4'h0)
    else $error("lane driven while paused");
  chk_quad_no_pause: assert property (quadEnable && $past(quadEnable) |-> !$rose(paused))
    else $error("pause taken in quad operation");
  chk_quad_no_wp: assert property (quadEnable && $past(quadEnable) |-> !writeProtectActive)
    else $error("write protect active in quad operation");
  chk_wp_status_block: assert property
    (statusWriteBlocked == (writeProtectActive && $past(statusProtectBit)))
    else $error("status block does not follow protect inputs");
  chk_out_on_fall: assert property (selected && $changed(pinDrive.laneOut) |-> !pinIn.sclk)
    else $error("output changed while serial clock high");
  chk_rx_on_rise: assert property (rxValid |-> pinIn.sclk && $past(pinIn.sclk, 2))
    else $error("byte completed away from a rising edge");
  chk_arm_first: assert property (frameStart |-> $past(armed))
    else $error("frame started before select was armed");
  chk_reset_low_time: assert property
    (hwResetPulse |-> lowCnt inside {[5'd11:5'd15]} && pinFunctionSelect && !quadEnable)
    else $error("hardware reset without a long enough low pulse");
  chk_narrow_lanes: assert property
    (!quadEnable && !$past(quadEnable) |-> pinDrive.laneOe[3:2] == 2'b00)
    else $error("upper lanes driven outside quad operation");

  // Main scenarios reached
  cov_frame: cover property (frameStart);
  cov_pause: cover property ($rose(paused));
  cov_reset: cover property (hwResetPulse);
endmodule // sfp_pin_frontend_monitor

bind sfp_pin_frontend sfp_pin_frontend_monitor mon (.mclk(mclk), .srst(srst), .pinIn(pinIn),
  .pinDrive(pinDrive), .quadEnable(quadEnable), .pinFunctionSelect(pinFunctionSelect),
  .statusProtectBit(statusProtectBit), .rxValid(rxValid), .selected(selected), .paused(paused),
  .armed(armed), .frameStart(frameStart), .hwResetPulse(hwResetPulse),
  .writeProtectActive(writeProtectActive), .statusWriteBlocked(statusWriteBlocked));

// >>> testbench/sfp_pin_frontend_tb.sv
`timescale 1ns/1ps
module sfp_pin_frontend_tb;
  import sfp_pkg::*;

  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic clkEn = 1'b1;
  logic quadEnable = 1'b0;
  logic pinFunctionSelect = PIN_FN_PAUSE;
  logic statusProtectBit = 1'b0;
  sfp_width_e laneMode = WIDTH_SINGLE;
  logic outPhase = 1'b0;
  logic [7:0] txByte = 8'h00;
  sfp_pins_s pinIn;
  sfp_drive_s pinDrive;
  logic txTake, rxValid, selected, paused, armed, frameStart, frameEnd;
  logic hwResetPulse, writeProtectActive, statusWriteBlocked;
  logic [7:0] rxByte;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int pulses = 0;
  int starts = 0; // Frame start pulses
  int ends = 0; // Frame end pulses
  int rxPulses = 0; // Received byte pulses
  int takes = 0; // Send byte take pulses
  logic [7:0] pat [3] = '{8'ha5, 8'h96, 8'hc3}; // Byte per lane mode
  logic [3:0] oeExp [3] = '{OE_SINGLE, OE_DUAL, OE_QUAD}; // Send enables per mode
  logic [7:0] keep;

  always #50 mclk = ~mclk; // 10 MHz

  sfp_pin_frontend dut (.mclk(mclk), .srst(srst), .clkEn(clkEn), .pinIn(pinIn),
    .pinDrive(pinDrive), .quadEnable(quadEnable), .pinFunctionSelect(pinFunctionSelect),
    .statusProtectBit(statusProtectBit), .laneMode(laneMode), .outPhase(outPhase),
    .txByte(txByte), .txTake(txTake), .rxByte(rxByte), .rxValid(rxValid),
    .selected(selected), .paused(paused), .armed(armed), .frameStart(frameStart),
    .frameEnd(frameEnd), .hwResetPulse(hwResetPulse),
    .writeProtectActive(writeProtectActive), .statusWriteBlocked(statusWriteBlocked));
  sfp_host_model host (.mclk(mclk), .pinDrive(pinDrive), .pinIn(pinIn));

  // Cycle ceiling and counts of reset, frame start, frame end, received byte and take pulses
  always @(negedge mclk) begin
    cycles++;
    if (hwResetPulse === 1'b1) pulses++;
    if (frameStart === 1'b1) starts++;
    if (frameEnd === 1'b1) ends++;
    if (rxValid === 1'b1) rxPulses++;
    if (txTake === 1'b1) takes++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // Compare and count
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Select the device and clock n times
  task automatic frame(input logic ph, input logic [7:0] v, input int n);
    outPhase = ph;
    txByte = v;
    host.txSh = v;
    host.selN = 1'b0;
    host.tick(6);
    host.clocks(n);
  endtask

  // Deselect and let it settle
  task automatic endf();
    host.selN = 1'b1;
    host.tick(8);
  endtask

  task automatic report_and_stop();
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    host.tick(16);
    srst = 1'b0;
    // Select low since power-up must not open a frame
    host.tick(8);
    chk("selected", 8'h00, 8'(selected));
    host.txSh = 8'hff;
    host.clocks(8);
    chk("rxByte", 8'h00, rxByte);
    endf();
    chk("armed", 8'h01, 8'(armed));
    // Receive then send in each lane width
    for (int m = 0; m < 3; m++) begin
      laneMode = sfp_width_e'(m);
      quadEnable = (m == 2);
      host.bpc = 1 << m;
      frame(1'b0, pat[m], 8 >> m);
      endf();
      chk("rxByte", pat[m], rxByte);
      // Output starts at the fall that ends a byte, so one filler byte first
      frame(1'b1, ~pat[m], 16 >> m);
      chk("laneOe", 8'(oeExp[m]), 8'(pinDrive.laneOe));
      endf();
      chk("sent", ~pat[m], host.rxSh);
      chk("laneOeOff", 8'(OE_NONE), 8'(pinDrive.laneOe));
      host.hostLane = 4'hf;
    end
    laneMode = WIDTH_SINGLE;
    quadEnable = 1'b0;
    host.bpc = 1;
    // Clock enable low freezes everything, so clocks then go unseen
    frame(1'b0, 8'h3c, 4);
    clkEn = 1'b0;
    keep = host.txSh;
    host.clocks(2);
    host.txSh = keep;
    clkEn = 1'b1;
    host.tick(4);
    host.clocks(4);
    endf();
    chk("rxFrozen", 8'h3c, rxByte);
    // Pause in mid-byte, stray clocks, then resume
    frame(1'b1, 8'h9b, 12);
    host.hostLane[LANE_THREE] = 1'b0;
    host.tick(6);
    chk("paused", 8'h01, 8'(paused));
    chk("laneOePause", 8'(OE_NONE), 8'(pinDrive.laneOe));
    keep = host.rxSh;
    host.clocks(2);
    host.rxSh = keep;
    host.hostLane[LANE_THREE] = 1'b1;
    host.tick(6);
    host.clocks(4);
    chk("resumed", 8'h9b, host.rxSh);
    endf();
    // Write protect with and without quad operation
    host.hostLane[LANE_TWO] = 1'b0;
    statusProtectBit = 1'b1;
    host.tick(5);
    chk("wpActive", 8'h01, 8'(writeProtectActive));
    chk("stBlocked", 8'h01, 8'(statusWriteBlocked));
    quadEnable = 1'b1;
    host.tick(3);
    chk("wpQuad", 8'h00, 8'(writeProtectActive));
    quadEnable = 1'b0;
    host.hostLane[LANE_TWO] = 1'b1;
    // Hardware reset: short low ignored, long low aborts
    pinFunctionSelect = PIN_FN_RESET;
    frame(1'b0, 8'h00, 3);
    host.hostLane[LANE_THREE] = 1'b0;
    host.tick(8);
    host.hostLane[LANE_THREE] = 1'b1;
    host.tick(5);
    chk("shortLow", 8'h00, 8'(pulses));
    chk("kept", 8'h01, 8'(selected));
    host.hostLane[LANE_THREE] = 1'b0;
    host.tick(16);
    chk("pulses", 8'h01, 8'(pulses));
    chk("aborted", 8'h00, 8'(selected));
    chk("armedHw", 8'h00, 8'(armed));
    host.hostLane[LANE_THREE] = 1'b1;
    endf();
    chk("rearmed", 8'h01, 8'(armed));
    chk("frameStarts", 8'd9, 8'(starts));
    chk("frameEnds", 8'd9, 8'(ends));
    chk("rxPulses", 8'd4, 8'(rxPulses));
    chk("txTakes", 8'd8, 8'(takes));
    report_and_stop();
  end
endmodule // sfp_pin_frontend_tb
